// *** include/fsc_params.svh ***
// Constants for the sensor fusion session controller: offsets, fields, resets, encodings.
// Included by the package and by every design file; guarded against double inclusion.
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
`define FSC_AW          8
`define FSC_DEPTH       256
`define FSC_IW          32
`define FSC_DW          16
`define FSC_OP_MSB      31
`define FSC_OP_LSB      28
`define FSC_A_MSB       23
`define FSC_A_LSB       16
`define FSC_IMM_MSB     15
`define FSC_IMM_LSB     0
`define FSC_PC_START    8'h00
`define FSC_ACC_RST     16'h0000
`define FSC_SM_MBOX     8'h00
`define FSC_SM_TAB      8'h10
`define FSC_SM_DAT      8'h20
`define FSC_SM_CFG      8'h30
`define FSC_SM_NRT      8
`define FSC_SM_WRBIT    15
`define FSC_WBA         15
`define FSC_HTRANS_IDLE 2'h0
`define FSC_HTRANS_NSEQ 2'h2
`define FSC_HSIZE_HALF  3'h1
`define FSC_AHB_BASE    32'h0000_0000
`define FSC_AHB_STEP    32'h0000_0004
`endif

// *** include/fsc_pkg.sv ***
// Types shared by the sensor fusion session controller files.
// Widths come from fsc_params.svh.
`include "fsc_params.svh"
package fsc_pkg;
  typedef logic [`FSC_AW-1:0] fsc_addr_t;
  typedef logic [`FSC_DW-1:0] fsc_data_t;
  typedef logic [`FSC_IW-1:0] fsc_inst_t;
  typedef enum logic [3:0] {
    OP_NOP  = 4'h0, OP_STOP = 4'h1, OP_LDI = 4'h2, OP_LDM = 4'h3,
    OP_STM  = 4'h4, OP_ADD  = 4'h5, OP_MBX = 4'h6, OP_WSM = 4'h7,
    OP_RSM  = 4'h8, OP_GO   = 4'h9, OP_WAIT = 4'ha, OP_OUT = 4'hb,
    OP_MUL  = 4'hc
  } fsc_op_e;
  typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_EXEC} fsc_eng_e;
  typedef enum logic [1:0] {SM_IDLE, SM_SCAN, SM_BUS} fsc_sm_e;
  typedef enum logic [1:0] {PO_IDLE, PO_FIFO, PO_ADDR, PO_DATA} fsc_po_e;
endpackage : fsc_pkg

// *** verilog/fsc_pkt_out.sv ***
// Result packet output: one 16-bit result leaves on the packet FIFO port or the AHB master.
// Assumes the FIFO sink and AHB slave run on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_pkt_out
  import fsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sel_ahb,
  input  wire logic        req,
  input  wire fsc_data_t   data,
  output logic             rdy,
  output logic             pkt_valid,
  output fsc_data_t        pkt_data,
  input  wire logic        pkt_ready,
  output logic [1:0]       htrans,
  output logic [31:0]      haddr,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready
);
  fsc_po_e     st_q, st_d;
  logic [31:0] ptr_q, ptr_d;
  fsc_data_t   dat_q, dat_d;
  logic [1:0]  htr_q, htr_d;
  logic        vld_q, vld_d, wr_q, wr_d;

  assign rdy       = (st_q == PO_IDLE);
  assign pkt_valid = vld_q;
  assign pkt_data  = dat_q;
  assign htrans    = htr_q;
  assign haddr     = ptr_q;
  assign hwrite    = wr_q;
  assign hsize     = `FSC_HSIZE_HALF;
  assign hwdata    = {16'h0000, dat_q};

  always_comb begin
    st_d  = st_q;
    ptr_d = ptr_q;
    dat_d = dat_q;
    case (st_q)
      PO_IDLE: begin
        if (req) begin
          dat_d = data;
          st_d  = sel_ahb ? PO_ADDR : PO_FIFO;
        end
      end
      PO_FIFO: if (pkt_ready) st_d = PO_IDLE;
      PO_ADDR: if (hready) st_d = PO_DATA;
      PO_DATA: begin
        if (hready) begin
          ptr_d = ptr_q + `FSC_AHB_STEP;
          st_d  = PO_IDLE;
        end
      end
      default: st_d = PO_IDLE;
    endcase
    vld_d = (st_d == PO_FIFO);
    htr_d = (st_d == PO_ADDR) ? `FSC_HTRANS_NSEQ : `FSC_HTRANS_IDLE;
    wr_d  = (st_d == PO_ADDR);
  end

  // Flops drive the packet and AHB ports directly and rdy only decodes st_q, so no port sees a path from an input.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q  <= PO_IDLE;
      ptr_q <= `FSC_AHB_BASE;
      dat_q <= `FSC_ACC_RST;
      vld_q <= 1'b0;
      htr_q <= `FSC_HTRANS_IDLE;
      wr_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      ptr_q <= ptr_d;
      dat_q <= dat_d;
      vld_q <= vld_d;
      htr_q <= htr_d;
      wr_q  <= wr_d;
    end
  end
endmodule : fsc_pkt_out
`default_nettype wire

// *** verilog/fsc_smgr.sv ***
// Sensor manager: memory with mailbox, routine table, data area and a Wishbone master.
// Assumes the I2C/SPI masters answer on Wishbone with wb_ack_i on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_smgr
  import fsc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             host_we,
  input  wire fsc_addr_t        host_addr,
  input  wire fsc_data_t        host_wdata,
  input  wire logic             eng_we,
  input  wire fsc_addr_t        eng_addr,
  input  wire fsc_data_t        eng_wdata,
  output fsc_data_t             eng_rdata,
  input  wire logic             go,
  output logic                  busy,
  output logic                  done,
  output logic                  wb_cyc_o,
  output logic                  wb_stb_o,
  output logic                  wb_we_o,
  output logic [`FSC_WBA-1:0]   wb_adr_o,
  output fsc_data_t             wb_dat_o,
  input  wire fsc_data_t        wb_dat_i,
  input  wire logic             wb_ack_i
);
  fsc_data_t mem [0:`FSC_DEPTH-1];
  fsc_sm_e   st_q, st_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] mbx_q, mbx_d;
  logic busy_q, busy_d, done_q, done_d, cyc_q, cyc_d, we_q, we_d;
  logic [`FSC_WBA-1:0] adr_q, adr_d;
  fsc_data_t wdo_q, wdo_d;
  logic      m_we;
  fsc_addr_t m_addr;
  fsc_data_t m_wdata, ent;

  function automatic fsc_addr_t slot(input fsc_addr_t base, input logic [2:0] i);
    slot = base | {5'h00, i};
  endfunction : slot

  assign eng_rdata = mem[eng_addr];
  assign busy      = busy_q;
  assign done      = done_q;
  assign wb_cyc_o  = cyc_q;
  assign wb_stb_o  = cyc_q;
  assign wb_we_o   = we_q;
  assign wb_adr_o  = adr_q;
  assign wb_dat_o  = wdo_q;
  assign ent       = mem[slot(`FSC_SM_TAB, idx_q)];

  always_comb begin
    st_d = st_q;  idx_d = idx_q;  mbx_d = mbx_q;  busy_d = busy_q;
    done_d = 1'b0;  cyc_d = cyc_q;  we_d = we_q;  adr_d = adr_q;  wdo_d = wdo_q;
    m_we = 1'b0;  m_addr = host_addr;  m_wdata = host_wdata;
    if (host_we) m_we = 1'b1;
    if (eng_we && !busy_q) begin
      m_we = 1'b1;  m_addr = eng_addr;  m_wdata = eng_wdata;
    end
    case (st_q)
      SM_IDLE: begin
        if (go) begin
          mbx_d = mem[`FSC_SM_MBOX][7:0];  idx_d = 3'h0;  busy_d = 1'b1;  st_d = SM_SCAN;
        end
      end
      SM_SCAN: begin
        if (mbx_q[idx_q]) begin
          cyc_d = 1'b1;  we_d = ent[`FSC_SM_WRBIT];  adr_d = ent[`FSC_WBA-1:0];
          wdo_d = mem[slot(`FSC_SM_CFG, idx_q)];  st_d = SM_BUS;
        end else if (idx_q == 3'h7) begin
          busy_d = 1'b0;  done_d = 1'b1;  st_d = SM_IDLE;
        end else idx_d = idx_q + 3'h1;
      end
      SM_BUS: begin
        if (wb_ack_i) begin
          cyc_d = 1'b0;
          if (!we_q) begin
            m_we = 1'b1;  m_addr = slot(`FSC_SM_DAT, idx_q);  m_wdata = wb_dat_i;
          end
          if (idx_q == 3'h7) begin
            busy_d = 1'b0;  done_d = 1'b1;  st_d = SM_IDLE;
          end else begin
            idx_d = idx_q + 3'h1;  st_d = SM_SCAN;
          end
        end
      end
      default: st_d = SM_IDLE;
    endcase
  end

  // only moves data; no arithmetic path here.
  always_ff @(posedge clk) begin
    if (m_we) mem[m_addr] <= m_wdata;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= SM_IDLE;  idx_q <= 3'h0;  mbx_q <= 8'h00;  busy_q <= 1'b0;  done_q <= 1'b0;
      cyc_q <= 1'b0;  we_q <= 1'b0;  adr_q <= '0;  wdo_q <= `FSC_ACC_RST;
    end else begin
      st_q <= st_d;  idx_q <= idx_d;  mbx_q <= mbx_d;  busy_q <= busy_d;  done_q <= done_d;
      cyc_q <= cyc_d;  we_q <= we_d;  adr_q <= adr_d;  wdo_q <= wdo_d;
    end
  end
endmodule : fsc_smgr
`default_nettype wire

// *** verilog/fsc_session_ctrl.sv ***
// Sensor fusion session controller: the fusion engine sequencer with its own
// instruction and data memories, driving a sensor manager and a packet output.
// Assumes host load ports, start and mailbox come from logic on core_clk.
// Operation
// - Engine stays idle until host start, then runs a session.
// - Each session fetches from address zero until a stop instruction.
// - Engine has no write path into its instruction memory.
// - Sensor manager cannot read or write the engine instruction memory.
// - Data memory is written only by host and engine.
// - Engine writes mailbox values into sensor manager memory.
// - Engine reads sensor data before launching the next manager session.
// - Engine launches manager sessions and keeps computing while they run.
// - Results leave over packet FIFO port or AHB master.
// - Host steers sessions through a mailbox value, not memory rewrites.
// - Sensor manager runs only the routines its mailbox enables.
// - Sensor manager reaches sensors only over Wishbone to I2C/SPI masters.
// - Sensor manager stores retrieved data in its own memory.
// - Sensor manager performs no fusion arithmetic.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_session_ctrl
  import fsc_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           sys_rst,
  input  wire logic           host_start,
  input  wire fsc_data_t      host_mbox,
  input  wire logic           host_imem_we,
  input  wire fsc_addr_t      host_imem_addr,
  input  wire fsc_inst_t      host_imem_wdata,
  input  wire logic           host_dmem_we,
  input  wire fsc_addr_t      host_dmem_addr,
  input  wire fsc_data_t      host_dmem_wdata,
  output fsc_data_t           host_dmem_rdata,
  input  wire logic           host_smem_we,
  input  wire fsc_addr_t      host_smem_addr,
  input  wire fsc_data_t      host_smem_wdata,
  input  wire logic           out_sel_ahb,
  output logic                session_active,
  output logic                session_done,
  output logic                pkt_valid,
  output fsc_data_t           pkt_data,
  input  wire logic           pkt_ready,
  output logic [1:0]          htrans,
  output logic [31:0]         haddr,
  output logic                hwrite,
  output logic [2:0]          hsize,
  output logic [31:0]         hwdata,
  input  wire logic           hready,
  output logic                wb_cyc_o,
  output logic                wb_stb_o,
  output logic                wb_we_o,
  output logic [`FSC_WBA-1:0] wb_adr_o,
  output fsc_data_t           wb_dat_o,
  input  wire fsc_data_t      wb_dat_i,
  input  wire logic           wb_ack_i
);
  fsc_inst_t imem [0:`FSC_DEPTH-1];
  fsc_data_t dmem [0:`FSC_DEPTH-1];

  fsc_eng_e  st_q, st_d;
  fsc_addr_t pc_q, pc_d;
  fsc_inst_t ir_q, ir_d;
  fsc_data_t acc_q, acc_d;
  logic      act_q, act_d;
  logic      done_q, done_d;
  fsc_data_t hrd_q, hrd_d;

  fsc_op_e   op;
  fsc_addr_t fa;
  fsc_data_t imm;
  fsc_data_t opnd;
  logic      adv;

  logic      dm_we;
  fsc_addr_t dm_addr;
  fsc_data_t dm_wdata;

  logic      sm_we;
  fsc_addr_t sm_addr;
  logic      sm_go;
  logic      sm_busy;
  logic      sm_done;
  fsc_data_t sm_rdata;

  logic      out_req;
  logic      out_rdy;

  function automatic fsc_op_e f_op(input fsc_inst_t i);
    f_op = fsc_op_e'(i[`FSC_OP_MSB:`FSC_OP_LSB]);
  endfunction : f_op

  function automatic fsc_addr_t f_addr(input fsc_inst_t i);
    f_addr = i[`FSC_A_MSB:`FSC_A_LSB];
  endfunction : f_addr

  function automatic fsc_data_t f_imm(input fsc_inst_t i);
    f_imm = i[`FSC_IMM_MSB:`FSC_IMM_LSB];
  endfunction : f_imm

  // Keeps the low half of the product; fixed point scaling is left to the program.
  function automatic fsc_data_t mul_lo(input fsc_data_t a, input fsc_data_t b);
    logic [2*`FSC_DW-1:0] p;
    p = a * b;
    mul_lo = p[`FSC_DW-1:0];
  endfunction : mul_lo

  assign op   = f_op(ir_q);
  assign fa   = f_addr(ir_q);
  assign imm  = f_imm(ir_q);
  assign opnd = dmem[fa];
  assign sm_addr = (op == OP_RSM) ? fa : `FSC_SM_MBOX;

  assign host_dmem_rdata = hrd_q;
  assign session_active  = act_q;
  assign session_done    = done_q;

  // Engine sequencer.
  always_comb begin
    st_d    = st_q;
    pc_d    = pc_q;
    ir_d    = ir_q;
    acc_d   = acc_q;
    act_d   = act_q;
    done_d  = 1'b0;
    sm_we   = 1'b0;
    sm_go   = 1'b0;
    out_req = 1'b0;
    adv     = 1'b0;
    case (st_q)
      ENG_IDLE: begin
        if (host_start) begin
          pc_d  = `FSC_PC_START;
          act_d = 1'b1;
          st_d  = ENG_FETCH;
        end
      end
      ENG_FETCH: begin
        ir_d = imem[pc_q];
        st_d = ENG_EXEC;
      end
      ENG_EXEC: begin
        adv = 1'b1;
        case (op)
          OP_STOP: begin
            adv    = 1'b0;
            act_d  = 1'b0;
            done_d = 1'b1;
            st_d   = ENG_IDLE;
          end
          OP_LDI: acc_d = imm;
          OP_LDM: acc_d = opnd;
          OP_ADD: acc_d = acc_q + opnd;
          OP_MUL: acc_d = mul_lo(acc_q, opnd);
          OP_MBX: acc_d = host_mbox;
          OP_WSM: begin
            if (sm_busy) begin
              adv = 1'b0;
            end else begin
              sm_we = 1'b1;
            end
          end
          OP_RSM: begin
            if (sm_busy) begin
              adv = 1'b0;
            end else begin
              acc_d = sm_rdata;
            end
          end
          OP_GO: begin
            if (sm_busy) begin
              adv = 1'b0;
            end else begin
              sm_go = 1'b1;
            end
          end
          OP_WAIT: adv = !sm_busy;
          OP_OUT: begin
            if (out_rdy) begin
              out_req = 1'b1;
            end else begin
              adv = 1'b0;
            end
          end
          default: adv = 1'b1;
        endcase
        if (adv) begin
          pc_d = pc_q + 8'h01;
          st_d = ENG_FETCH;
        end
      end
      default: st_d = ENG_IDLE;
    endcase
  end

  // Data memory port select and host read-back.
  always_comb begin
    dm_we    = host_dmem_we;
    dm_addr  = host_dmem_addr;
    dm_wdata = host_dmem_wdata;
    // The engine wins a same-cycle clash, so a running program never loses its store.
    if (st_q == ENG_EXEC && op == OP_STM) begin
      dm_we    = 1'b1;
      dm_addr  = fa;
      dm_wdata = acc_q;
    end
    hrd_d = dmem[host_dmem_addr];
  end

  always_ff @(posedge core_clk) begin
    if (host_imem_we) begin
      imem[host_imem_addr] <= host_imem_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (dm_we) begin
      dmem[dm_addr] <= dm_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q   <= ENG_IDLE;
      pc_q   <= `FSC_PC_START;
      ir_q   <= '0;
      acc_q  <= `FSC_ACC_RST;
      act_q  <= 1'b0;
      done_q <= 1'b0;
      hrd_q  <= `FSC_ACC_RST;
    end else begin
      st_q   <= st_d;
      pc_q   <= pc_d;
      ir_q   <= ir_d;
      acc_q  <= acc_d;
      act_q  <= act_d;
      done_q <= done_d;
      hrd_q  <= hrd_d;
    end
  end

  // manager has no instruction memory port.
  fsc_smgr u_smgr (
    .clk        (core_clk),
    .rst        (sys_rst),
    .host_we    (host_smem_we),
    .host_addr  (host_smem_addr),
    .host_wdata (host_smem_wdata),
    .eng_we     (sm_we),
    .eng_addr   (sm_addr),
    .eng_wdata  (acc_q),
    .eng_rdata  (sm_rdata),
    .go         (sm_go),
    .busy       (sm_busy),
    .done       (sm_done),
    .wb_cyc_o   (wb_cyc_o),
    .wb_stb_o   (wb_stb_o),
    .wb_we_o    (wb_we_o),
    .wb_adr_o   (wb_adr_o),
    .wb_dat_o   (wb_dat_o),
    .wb_dat_i   (wb_dat_i),
    .wb_ack_i   (wb_ack_i)
  );

  fsc_pkt_out u_pkt (
    .clk       (core_clk),
    .rst       (sys_rst),
    .sel_ahb   (out_sel_ahb),
    .req       (out_req),
    .data      (acc_q),
    .rdy       (out_rdy),
    .pkt_valid (pkt_valid),
    .pkt_data  (pkt_data),
    .pkt_ready (pkt_ready),
    .htrans    (htrans),
    .haddr     (haddr),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready)
  );
endmodule : fsc_session_ctrl
`default_nettype wire

// *** verif/fsc_session_ctrl_sva.sv ***
// Checker for the fusion session controller top: session, packet, AHB and Wishbone timing.
// Sees only top-level ports and is bound to every fsc_session_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_session_ctrl_sva
  import fsc_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire logic                host_start,
  input wire logic                session_active,
  input wire logic                session_done,
  input wire logic                pkt_valid,
  input wire fsc_data_t           pkt_data,
  input wire logic                pkt_ready,
  input wire logic [1:0]          htrans,
  input wire logic [31:0]         haddr,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic                hready,
  input wire logic                wb_cyc_o,
  input wire logic                wb_stb_o,
  input wire logic                wb_we_o,
  input wire logic [`FSC_WBA-1:0] wb_adr_o,
  input wire logic                wb_ack_i
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_start; !session_active && !session_done && host_start |=> session_active; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_idle; $rose(session_active) |-> $past(host_start); endproperty
  a_idle: assert property (p_idle) else $error("session began without start");
  property p_done; $fell(session_active) |-> session_done ##1 !session_done; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_done_end; session_done |-> !session_active && $past(session_active); endproperty
  a_done_end: assert property (p_done_end) else $error("done outside session end");
  property p_pkt_hold; pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data); endproperty
  a_pkt_hold: assert property (p_pkt_hold) else $error("packet dropped");
  property p_ahb_hold; htrans == 2'h2 && !hready |=> htrans == 2'h2 && $stable(haddr); endproperty
  a_ahb_hold: assert property (p_ahb_hold) else $error("ahb address dropped");
  property p_ahb_fmt; htrans == 2'h2 |-> hwrite && hsize == 3'h1 && haddr[1:0] == 2'h0; endproperty
  a_ahb_fmt: assert property (p_ahb_fmt) else $error("ahb write format");
  property p_wb_hold; wb_stb_o && !wb_ack_i |=> wb_stb_o && $stable({wb_we_o, wb_adr_o}); endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("wishbone request dropped");
  property p_wb_pair; wb_cyc_o == wb_stb_o; endproperty
  a_wb_pair: assert property (p_wb_pair) else $error("cyc and stb differ");
  property p_wb_end; wb_stb_o && wb_ack_i |=> !wb_stb_o; endproperty
  a_wb_end: assert property (p_wb_end) else $error("strobe held after ack");
  c_session: cover property (session_done);
  c_pkt: cover property (pkt_valid && pkt_ready);
  c_ahb: cover property (htrans == 2'h2 && hready);
  c_wb: cover property (wb_stb_o && wb_ack_i);
endmodule : fsc_session_ctrl_sva
bind fsc_session_ctrl fsc_session_ctrl_sva u_sva (.*);
`default_nettype wire

// *** verif/fsc_wb_sensor_model.sv ***
// Wishbone slave standing in for the sensor bus masters, prompt or slow.
// Assumes one Wishbone master on core_clk; read data is a pattern of the address.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_wb_sensor_model
  import fsc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                slow_wb,
  input  wire logic                wb_cyc_o,
  input  wire logic                wb_stb_o,
  input  wire logic                wb_we_o,
  input  wire logic [`FSC_WBA-1:0] wb_adr_o,
  output fsc_data_t                wb_dat_i,
  output logic                     wb_ack_i
);
  logic [2:0] wait_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_i <= 1'b0;
      wait_q <= 3'h0;
      wb_dat_i <= 16'h0;
    end else if (wb_cyc_o && wb_stb_o && !wb_ack_i && wait_q >= (slow_wb ? 3'h3 : 3'h0)) begin
      wb_ack_i <= 1'b1;
      wb_dat_i <= wb_we_o ? ~wb_dat_i : ({1'b0, wb_adr_o} ^ 16'ha5a5);
      wait_q <= 3'h0;
    end else begin
      // Outside an ack the data toggles, so a late sample never looks valid.
      wb_ack_i <= 1'b0;
      wb_dat_i <= ~wb_dat_i;
      wait_q <= (wb_stb_o && !wb_ack_i) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule : fsc_wb_sensor_model
`default_nettype wire

// *** verif/fsc_session_ctrl_bench.sv ***
// Self-checking bench for the fusion session controller with a Wishbone sensor model.
// Assumes the package, the design, the checker and the model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module fsc_session_ctrl_bench
  import fsc_pkg::*;
;
  logic core_clk = 1'b0, sys_rst = 1'b1, host_start = 1'b0, host_imem_we = 1'b0;
  logic host_dmem_we = 1'b0, host_smem_we = 1'b0, out_sel_ahb = 1'b0;
  logic pkt_ready = 1'b1, hready = 1'b1, slow_wb = 1'b0, stall = 1'b0, ahb_dph = 1'b0;
  fsc_data_t host_mbox = 16'h0, host_dmem_wdata = 16'h0, host_smem_wdata = 16'h0;
  fsc_addr_t host_imem_addr = 8'h0, host_dmem_addr = 8'h0, host_smem_addr = 8'h0;
  fsc_inst_t host_imem_wdata = 32'h0;
  fsc_data_t host_dmem_rdata, pkt_data, wb_dat_o, wb_dat_i, s, m;
  logic session_active, session_done, pkt_valid, hwrite, wb_cyc_o, wb_stb_o, wb_we_o, wb_ack_i;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, ahb_ptr = 32'h0;
  logic [`FSC_WBA-1:0] wb_adr_o;
  logic [7:0] mask;
  int n_errors = 0, tests_run = 0, cycles = 0, n_done = 0, n_runs = 0;
  fsc_data_t exp_q[$], tab[8], cfg[8], d[3];
  logic [31:0] wb_q[$];
  fsc_inst_t prog[$];

  always #2 core_clk = ~core_clk;
  fsc_session_ctrl dut (.*);
  fsc_wb_sensor_model u_model (.*);

  always @(negedge core_clk) begin
    pkt_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
    hready <= stall ? 1'($urandom_range(1)) : 1'b1;
  end

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic take(fsc_data_t got);
    fsc_data_t e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
    `CHK(got, e)
  endtask : take

  function automatic fsc_inst_t ins(fsc_op_e op, fsc_addr_t a, fsc_data_t v);
    return {op, 4'h0, a, v};
  endfunction : ins

  // Selects 0 imem, 1 dmem, 2 smem, 3 none; one word per falling edge.
  task automatic wr(int sel, fsc_addr_t a, logic [31:0] v);
    @(negedge core_clk);
    host_imem_we = (sel == 0);
    host_dmem_we = (sel == 1);
    host_smem_we = (sel == 2);
    host_imem_addr = a;
    host_dmem_addr = a;
    host_smem_addr = a;
    host_imem_wdata = v;
    host_dmem_wdata = v[15:0];
    host_smem_wdata = v[15:0];
  endtask : wr

  task automatic rd(fsc_addr_t a, fsc_data_t e);
    @(negedge core_clk) host_dmem_addr = a;
    @(negedge core_clk) `CHK(host_dmem_rdata, e)
  endtask : rd

  task automatic run();
    int n;
    foreach (prog[i]) wr(0, fsc_addr_t'(i), prog[i]);
    wr(3, 8'h0, 32'h0);
    `CHK(session_active, 1'b0)
    host_start = 1'b1;
    @(negedge core_clk) host_start = 1'b0;
    `CHK(session_active, 1'b1)
    repeat (3) @(negedge core_clk);
    host_start = 1'b1;
    @(negedge core_clk) host_start = 1'b0;
    n = 0;
    while ((session_active !== 1'b0 || exp_q.size() != 0) && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    n_runs++;
    `CHK(session_active, 1'b0)
    `CHK(n_done, n_runs)
    `CHK(exp_q.size(), 0)
    `CHK(wb_q.size(), 0)
    prog.delete();
  endtask : run

  always @(posedge core_clk) begin
    logic [31:0] w;
    cycles++;
    if (cycles > 40000) begin
      n_errors++;
      close_out();
    end
    if (!sys_rst) begin
      if (session_done === 1'b1) n_done++;
      if (pkt_valid === 1'b1 && pkt_ready === 1'b1) take(pkt_data);
      if (ahb_dph && hready === 1'b1) begin
        take(hwdata[15:0]);
        `CHK(hwdata[31:16], 16'h0)
        ahb_dph <= 1'b0;
      end
      if (htrans === 2'h2 && hready === 1'b1) begin
        `CHK(haddr, ahb_ptr)
        ahb_ptr <= ahb_ptr + 32'h4;
        ahb_dph <= 1'b1;
      end
      if (wb_stb_o === 1'b1 && wb_ack_i === 1'b1) begin
        w = (wb_q.size() != 0) ? wb_q.pop_front() : 32'hx;
        `CHK({wb_we_o, wb_adr_o}, w[31:16])
        if (w[31]) `CHK(wb_dat_o, w[15:0])
      end
    end
  end

  initial begin
    void'($urandom(32'h3b23));
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    `CHK(session_active, 1'b0)
    `CHK(htrans, 2'h0)
    `CHK(wb_cyc_o, 1'b0)
    stall = 1'b1;
    s = 16'($urandom);
    // Same program twice, steered only by the mailbox; second run on AHB.
    for (int k = 0; k < 2; k++) begin
      out_sel_ahb = k[0];
      host_mbox = 16'($urandom);
      prog = '{ins(OP_MBX, 0, 0), ins(OP_OUT, 0, 0), ins(OP_LDI, 0, s), ins(OP_OUT, 0, 0),
               ins(OP_STOP, 0, 0)};
      exp_q = '{host_mbox, s};
      run();
    end
    foreach (d[i]) begin
      d[i] = 16'($urandom);
      wr(1, 8'h40 + 8'(i), {16'h0, d[i]});
    end
    s = d[0] + d[1];
    m = 16'(s * d[2]);
    prog = '{ins(OP_LDM, 8'h40, 0), ins(OP_ADD, 8'h41, 0), ins(OP_STM, 8'h50, 0),
             ins(OP_MUL, 8'h42, 0), ins(OP_STM, 8'h51, 0), ins(OP_OUT, 0, 0), ins(OP_STOP, 0, 0)};
    exp_q = '{m};
    run();
    rd(8'h50, s);
    rd(8'h51, m);
    for (int k = 0; k < 2; k++) begin
      out_sel_ahb = k[0];
      slow_wb = k[0];
      mask = (k == 0) ? (8'($urandom) | 8'h01) : 8'h80;
      for (int i = 0; i < 8; i++) begin
        tab[i] = 16'($urandom);
        cfg[i] = 16'($urandom);
        wr(2, 8'h10 + 8'(i), {16'h0, tab[i]});
        wr(2, 8'h30 + 8'(i), {16'h0, cfg[i]});
        wr(2, 8'h20 + 8'(i), 32'h0);
      end
      s = 16'($urandom);
      prog = '{ins(OP_LDI, 0, {8'h0, mask}), ins(OP_WSM, 0, 0), ins(OP_GO, 0, 0),
               ins(OP_LDI, 0, s), ins(OP_OUT, 0, 0), ins(OP_WAIT, 0, 0)};
      exp_q = '{s};
      for (int i = 0; i < 8; i++) begin
        if (mask[i]) begin
          wb_q.push_back({tab[i], cfg[i]});
          if (!tab[i][15]) begin
            prog.push_back(ins(OP_RSM, 8'h20 + 8'(i), 0));
            prog.push_back(ins(OP_OUT, 0, 0));
            exp_q.push_back({1'b0, tab[i][14:0]} ^ 16'ha5a5);
          end
        end
      end
      prog.push_back(ins(OP_STOP, 0, 0));
      run();
    end
    close_out();
  end
endmodule : fsc_session_ctrl_bench
`default_nettype wire
